// File: rtl/emb_pkg.sv
// Purpose: shared constants and types of the external bus pin functions
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   pin levels follow the board: strobes and selects are active low
package emb_pkg;

    // kind of memory behind the access in progress
    typedef enum logic [2:0] {
        KIND_NORMAL = 3'h0,
        KIND_DRAM   = 3'h1,
        KIND_SDRAM  = 3'h2,
        KIND_PSRAM  = 3'h3,
        KIND_CARD   = 3'h4
    } emb_kind_t;

    // bus release handshake
    typedef enum logic [0:0] {
        REL_IDLE    = 1'h0,
        REL_GRANTED = 1'h1
    } emb_rel_t;

    localparam int           NUM_AREAS        = 7;
    localparam int           NUM_LANES        = 4;
    localparam int           LANE_BITS        = 8;
    localparam int           PORT_LANE        = 2;
    localparam int           TOP_LANE         = 3;
    localparam logic [2:0]   AREA_TWO         = 3'h2;
    localparam logic [2:0]   AREA_CARD_A      = 3'h5;
    localparam logic [2:0]   AREA_CARD_B      = 3'h6;
    localparam logic [2:0]   MTYPE_AREA2_DRAM = 3'h5;
    localparam logic         RST_STROBE       = 1'h1;
    localparam logic [6:0]   RST_AREA_SEL     = 7'h7F;
    localparam logic [3:0]   RST_LANES        = 4'hF;
    localparam logic [25:0]  RST_ADDR         = 26'h0000000;
    localparam logic [31:0]  RST_DATA         = 32'h00000000;

endpackage

// File: rtl/emb_mode_pins.sv
// Purpose: mode pins that are read at reset and later turn into outputs
// Assumes: pins are plain inputs while reset is held low
// Notes:   captured levels hold until the next reset
module emb_mode_pins (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        width_pin_a_in,
    input  wire logic        width_pin_b_in,
    input  wire logic        endian_pin_in,
    input  wire logic        area5_card_sel,
    input  wire logic        area6_card_sel,
    input  wire logic [2:0]  memory_type_field,
    input  wire logic        next_card_enable_hi_a_n,
    input  wire logic        next_card_enable_hi_b_n,
    input  wire logic        next_area2_row_strobe_n,
    output logic             width_pin_a_out,
    output logic             width_pin_a_oe,
    output logic             width_pin_b_out,
    output logic             width_pin_b_oe,
    output logic             endian_pin_out,
    output logic             endian_pin_oe,
    output logic [1:0]       area0_width,
    output logic             endian_little
);

    // straps sampled every cycle of reset, frozen at release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            area0_width   <= {width_pin_b_in, width_pin_a_in};
            endian_little <= endian_pin_in;
        end
    end

    // direction of each pin follows its own configuration bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            width_pin_a_oe <= 1'b0;
            width_pin_b_oe <= 1'b0;
            endian_pin_oe  <= 1'b0;
        end else begin
            width_pin_a_oe <= area5_card_sel;
            width_pin_b_oe <= area6_card_sel;
            endian_pin_oe  <= (memory_type_field == emb_pkg::MTYPE_AREA2_DRAM);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            width_pin_a_out <= emb_pkg::RST_STROBE;
            width_pin_b_out <= emb_pkg::RST_STROBE;
            endian_pin_out  <= emb_pkg::RST_STROBE;
        end else begin
            width_pin_a_out <= next_card_enable_hi_a_n;
            width_pin_b_out <= next_card_enable_hi_b_n;
            endian_pin_out  <= next_area2_row_strobe_n;
        end
    end

endmodule

// File: rtl/emb_pin_functions.sv
// Purpose: pin function assignment of the external memory bus controller
// Assumes: core timing signals arrive one cycle before the pins show them
// Notes:   every pin is registered; address, strobe and data enables drop while the bus is released, except the third lane in port mode
// Operation
// - port mode: top data lane unused, left open
// - third lane is data or per-bit port
// - cycle start each cycle, each burst beat
// - seven area selects, areas 5/6 card enables
// - read/write shows direction, memory write indicator
// - row strobe for DRAM/SDRAM, chip enable pseudo-SRAM
// - four DRAM column strobes; lowest shared otherwise
// - area two DRAM uses upper column pins
// - data enables: SDRAM mask or write strobe
// - card access: second enable marks write
// - card access: third I/O read, fourth write
// - dedicated read strobe during read cycles
// - card wide I/O honoured only little-endian
// - clock enable output for synchronous DRAM
// - release request answered by release acknowledge
// - width pins read, later card high enables
// - width pins output only when card selected
// - endian pin read, area two row strobe
// - card access asserts high enable when lane 1 byte selected
// - each area select asserted during its access
module emb_pin_functions (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  core_active,
    input  wire logic                  core_cycle_start,
    input  wire logic                  core_burst_data,
    input  wire logic [2:0]            core_area,
    input  wire emb_pkg::emb_kind_t    core_kind,
    input  wire logic                  core_write,
    input  wire logic [3:0]            core_lanes,
    input  wire logic                  core_card_io,
    input  wire logic                  core_ras,
    input  wire logic                  core_cas,
    input  wire logic                  core_strobe,
    input  wire logic                  core_cke,
    input  wire logic                  core_data_oe,
    input  wire logic [25:0]           core_addr,
    input  wire logic [31:0]           core_wdata,
    input  wire logic                  port_func_en,
    input  wire logic [7:0]            port_dir,
    input  wire logic [7:0]            port_out,
    input  wire logic                  area5_card_sel,
    input  wire logic                  area6_card_sel,
    input  wire logic [2:0]            memory_type_field,
    input  wire logic                  wait_in_n,
    input  wire logic                  card_io_wide_in_n,
    input  wire logic                  release_request_in_n,
    input  wire logic [31:0]           data_in,
    input  wire logic                  width_pin_a_in,
    input  wire logic                  width_pin_b_in,
    input  wire logic                  endian_pin_in,
    output logic [31:0]                core_rdata,
    output logic [7:0]                 port_in,
    output logic                       core_wait,
    output logic                       core_card_wide,
    output logic                       core_released,
    output logic [1:0]                 area0_width,
    output logic                       endian_little,
    output logic [25:0]                addr_out,
    output logic                       addr_oe,
    output logic [31:0]                data_out,
    output logic [31:0]                data_oe,
    output logic                       strobe_oe,
    output logic                       cycle_start_out_n,
    output logic [6:0]                 area_selects_n,
    output logic                       rd_wr_out,
    output logic                       row_strobe_n,
    output logic                       col_strobe_lane0_n,
    output logic                       col_strobe_lane1_n,
    output logic                       col_strobe_lane2_n,
    output logic                       col_strobe_lane3_n,
    output logic                       lane0_enable,
    output logic                       lane1_enable,
    output logic                       lane2_enable,
    output logic                       lane3_enable,
    output logic                       read_strobe_n,
    output logic                       cke_out,
    output logic                       release_ack_out_n,
    output logic                       width_pin_a_out,
    output logic                       width_pin_a_oe,
    output logic                       width_pin_b_out,
    output logic                       width_pin_b_oe,
    output logic                       endian_pin_out,
    output logic                       endian_pin_oe
);

    logic                  is_dram;
    logic                  is_sdram;
    logic                  is_psram;
    logic                  is_card;
    logic                  area2_dram;
    logic                  wr_stb;
    logic                  rd_stb;
    logic                  bus_drive;
    logic [3:0]            col_n;
    logic [3:0]            lane_en;
    logic [3:0]            next_col_n;
    logic [3:0]            next_lane_en;
    logic [31:0]           next_data_oe;
    logic [31:0]           next_data_out;
    emb_pkg::emb_rel_t     rel_state;
    emb_pkg::emb_rel_t     next_rel_state;

    assign is_dram    = core_active && (core_kind == emb_pkg::KIND_DRAM);
    assign is_sdram   = core_active && (core_kind == emb_pkg::KIND_SDRAM);
    assign is_psram   = core_active && (core_kind == emb_pkg::KIND_PSRAM);
    assign is_card    = core_active && (core_kind == emb_pkg::KIND_CARD);
    assign area2_dram = is_dram && (core_area == emb_pkg::AREA_TWO)
                        && (memory_type_field == emb_pkg::MTYPE_AREA2_DRAM);
    assign wr_stb     = core_active && core_strobe && core_write;
    assign rd_stb     = core_active && core_strobe && !core_write;
    assign bus_drive  = (next_rel_state == emb_pkg::REL_IDLE);

    // release handshake: grant only between accesses
    always_comb begin
        case (rel_state)
            emb_pkg::REL_IDLE: begin
                if (!release_request_in_n && !core_active) begin
                    next_rel_state = emb_pkg::REL_GRANTED;
                end else begin
                    next_rel_state = emb_pkg::REL_IDLE;
                end
            end
            emb_pkg::REL_GRANTED: begin
                if (release_request_in_n) begin
                    next_rel_state = emb_pkg::REL_IDLE;
                end else begin
                    next_rel_state = emb_pkg::REL_GRANTED;
                end
            end
            default: next_rel_state = emb_pkg::REL_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rel_state         <= emb_pkg::REL_IDLE;
            release_ack_out_n <= emb_pkg::RST_STROBE;
            core_released     <= 1'b0;
            addr_oe           <= 1'b0;
            strobe_oe         <= 1'b0;
        end else begin
            rel_state         <= next_rel_state;
            release_ack_out_n <= bus_drive;
            core_released     <= !bus_drive;
            addr_oe           <= bus_drive;
            strobe_oe         <= bus_drive;
        end
    end

    // per-lane column strobes, data enables and data pins
    genvar k;
    generate
        for (k = 0; k < emb_pkg::NUM_LANES; k++) begin : g_lane
            if (k == 0) begin : g_low
                assign next_col_n[k] = !((is_dram && !area2_dram && core_cas && core_lanes[k])
                                       || ((is_sdram || is_psram) && core_cas));
            end else if (k == 1) begin : g_mid
                assign next_col_n[k] = !(is_dram && !area2_dram && core_cas && core_lanes[k]);
            end else begin : g_high
                assign next_col_n[k] = !((is_dram && !area2_dram && core_cas && core_lanes[k])
                                       || (area2_dram && core_cas && core_lanes[k-2]));
            end
            if (k == 1) begin : g_card_wr
                assign next_lane_en[k] = is_sdram ? !core_lanes[k]
                                       : is_card ? !wr_stb
                                       : !(wr_stb && core_lanes[k]);
            end else if (k == 2) begin : g_card_rd
                assign next_lane_en[k] = is_sdram ? !core_lanes[k]
                                       : is_card ? !(core_card_io && rd_stb)
                                       : !(wr_stb && core_lanes[k]);
            end else if (k == 3) begin : g_card_iw
                assign next_lane_en[k] = is_sdram ? !core_lanes[k]
                                       : is_card ? !(core_card_io && wr_stb)
                                       : !(wr_stb && core_lanes[k]);
            end else begin : g_plain
                assign next_lane_en[k] = is_sdram ? !core_lanes[k]
                                       : !(wr_stb && core_lanes[k]);
            end
            if (k == emb_pkg::TOP_LANE) begin : g_top
                assign next_data_oe[k*8 +: 8]  = {8{bus_drive && core_data_oe && !port_func_en}};
                assign next_data_out[k*8 +: 8] = core_wdata[k*8 +: 8];
            end else if (k == emb_pkg::PORT_LANE) begin : g_port
                assign next_data_oe[k*8 +: 8]  = port_func_en ? port_dir
                                               : {8{bus_drive && core_data_oe}};
                assign next_data_out[k*8 +: 8] = port_func_en ? port_out : core_wdata[k*8 +: 8];
            end else begin : g_data
                assign next_data_oe[k*8 +: 8]  = {8{bus_drive && core_data_oe}};
                assign next_data_out[k*8 +: 8] = core_wdata[k*8 +: 8];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            col_n    <= emb_pkg::RST_LANES;
            lane_en  <= emb_pkg::RST_LANES;
            data_oe  <= emb_pkg::RST_DATA;
            data_out <= emb_pkg::RST_DATA;
            addr_out <= emb_pkg::RST_ADDR;
        end else begin
            col_n    <= next_col_n;
            lane_en  <= next_lane_en;
            data_oe  <= next_data_oe;
            data_out <= next_data_out;
            addr_out <= core_addr;
        end
    end

    assign col_strobe_lane0_n = col_n[0];
    assign col_strobe_lane1_n = col_n[1];
    assign col_strobe_lane2_n = col_n[2];
    assign col_strobe_lane3_n = col_n[3];
    assign lane0_enable       = lane_en[0];
    assign lane1_enable       = lane_en[1];
    assign lane2_enable       = lane_en[2];
    assign lane3_enable       = lane_en[3];

    // cycle, select and direction strobes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cycle_start_out_n <= emb_pkg::RST_STROBE;
            area_selects_n    <= emb_pkg::RST_AREA_SEL;
            rd_wr_out         <= emb_pkg::RST_STROBE;
            row_strobe_n      <= emb_pkg::RST_STROBE;
            read_strobe_n     <= emb_pkg::RST_STROBE;
            cke_out           <= 1'b0;
        end else begin
            cycle_start_out_n <= !(core_cycle_start || core_burst_data);
            for (int i = 0; i < emb_pkg::NUM_AREAS; i++) begin
                area_selects_n[i] <= !(core_active && (core_area == 3'(i)));
            end
            rd_wr_out         <= !(core_active && core_write);
            row_strobe_n      <= !((is_dram || is_sdram || is_psram) && core_ras
                                   && !area2_dram);
            read_strobe_n     <= !rd_stb;
            cke_out           <= core_cke;
        end
    end

    // inputs from the far side, port readback
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            core_wait      <= 1'b0;
            core_card_wide <= 1'b0;
            core_rdata     <= emb_pkg::RST_DATA;
            port_in        <= 8'h00;
        end else begin
            core_wait      <= !wait_in_n;
            core_card_wide <= endian_little && !card_io_wide_in_n;
            core_rdata     <= data_in;
            port_in        <= data_in[23:16];
        end
    end

    emb_mode_pins u_mode_pins (
        .clock                   (clock),
        .rst_n                   (rst_n),
        .width_pin_a_in          (width_pin_a_in),
        .width_pin_b_in          (width_pin_b_in),
        .endian_pin_in           (endian_pin_in),
        .area5_card_sel          (area5_card_sel),
        .area6_card_sel          (area6_card_sel),
        .memory_type_field       (memory_type_field),
        .next_card_enable_hi_a_n (!(is_card && core_area == emb_pkg::AREA_CARD_A
                                    && core_lanes[1])),
        .next_card_enable_hi_b_n (!(is_card && core_area == emb_pkg::AREA_CARD_B
                                    && core_lanes[1])),
        .next_area2_row_strobe_n (!(area2_dram && core_ras)),
        .width_pin_a_out         (width_pin_a_out),
        .width_pin_a_oe          (width_pin_a_oe),
        .width_pin_b_out         (width_pin_b_out),
        .width_pin_b_oe          (width_pin_b_oe),
        .endian_pin_out          (endian_pin_out),
        .endian_pin_oe           (endian_pin_oe),
        .area0_width             (area0_width),
        .endian_little           (endian_little)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_release_asked;
        !release_request_in_n && !core_active && rel_state == emb_pkg::REL_IDLE;
    endsequence
    sequence s_bus_floated;
        !release_ack_out_n && !addr_oe && !strobe_oe && data_oe[15:0] == 16'h0000;
    endsequence
    sequence s_request_dropped;
        release_request_in_n && rel_state == emb_pkg::REL_GRANTED;
    endsequence

    a_top_lane_open: assert property (port_func_en |=> data_oe[31:24] == 8'h00)
        else $error("top lane driven in port mode");
    a_port_lane_dir: assert property (port_func_en |=>
        data_oe[23:16] == $past(port_dir) && data_out[23:16] == $past(port_out))
        else $error("port lane not following port settings");
    a_cycle_start: assert property (1'b1 |=>
        cycle_start_out_n == !$past(core_cycle_start || core_burst_data))
        else $error("cycle start does not follow core");
    a_card_select: assert property (is_card && core_area == emb_pkg::AREA_CARD_B
        |=> !area_selects_n[6] && area_selects_n[5])
        else $error("card low enable wrong");
    a_area_select: assert property (core_active |=>
        area_selects_n == ~(7'h01 << $past(core_area)))
        else $error("area select does not match area");
    a_rd_wr_dir: assert property (core_active |=> rd_wr_out == !$past(core_write))
        else $error("read/write level wrong");
    a_row_psram: assert property (is_psram && core_ras |=> !row_strobe_n)
        else $error("pseudo-SRAM chip enable missing");
    a_col_lanes: assert property (is_dram && !area2_dram && core_cas |=>
        {col_strobe_lane3_n, col_strobe_lane2_n, col_strobe_lane1_n}
        == ~$past(core_lanes[3:1]))
        else $error("DRAM column strobes wrong");
    a_area2_cols: assert property (area2_dram && core_cas |=>
        col_strobe_lane2_n == !$past(core_lanes[0]) && col_strobe_lane0_n
        && !endian_pin_out == $past(core_ras))
        else $error("area two strobes wrong");
    a_sdram_mask: assert property (is_sdram |=>
        {lane3_enable, lane2_enable, lane1_enable, lane0_enable}
        == ~$past(core_lanes))
        else $error("synchronous DRAM lane mask wrong");
    a_card_write: assert property (is_card && wr_stb |=> !lane1_enable)
        else $error("card write strobe missing");
    a_card_io: assert property (is_card && core_card_io && core_strobe |=>
        lane2_enable == $past(core_write) && lane3_enable == !$past(core_write))
        else $error("card I/O strobes wrong");
    a_read_strobe: assert property (1'b1 |=> read_strobe_n == !$past(rd_stb))
        else $error("read strobe wrong");
    a_card_wide: assert property (!endian_little |=> !core_card_wide)
        else $error("wide I/O honoured in big-endian");
    a_cke_follow: assert property (1'b1 |=> cke_out == $past(core_cke))
        else $error("clock enable not following core");
    a_release_grant: assert property (s_release_asked |=> s_bus_floated)
        else $error("release not granted or bus still driven");
    a_release_end: assert property (s_request_dropped |=>
        release_ack_out_n && addr_oe && strobe_oe)
        else $error("release not withdrawn");
    a_width_dir: assert property (##1 width_pin_a_oe == $past(area5_card_sel)
        && width_pin_b_oe == $past(area6_card_sel))
        else $error("width pin direction wrong");
    a_endian_dir: assert property (memory_type_field != emb_pkg::MTYPE_AREA2_DRAM
        |=> !endian_pin_oe)
        else $error("endian pin driven without area two DRAM");
    a_card_high: assert property (is_card && core_area == emb_pkg::AREA_CARD_A
        && core_lanes[1] |=> !width_pin_a_out)
        else $error("card high enable missing");

endmodule

// File: verif/emb_mem_model.sv
// Purpose: board side of the bus, memory data and wait source
// Assumes: undriven data lines read back as the inverse of the last value
// Notes:   wait request is launched on the bus clock
module emb_mem_model (
    input  wire logic        clock,
    input  wire logic        slow,
    input  wire logic [31:0] data_out,
    input  wire logic [31:0] data_oe,
    output logic [31:0]      data_in,
    output logic             wait_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign data_in = (data_out & data_oe) | (~data_out & ~data_oe);
    always_ff @(posedge clock) wait_in_n <= ~slow;
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench of the bus pin functions
// Assumes: pins follow the core one clock later
// Notes:   inputs change on the falling edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, slow = 0;
    logic core_active, core_cycle_start, core_burst_data, core_write, core_card_io, core_ras;
    logic core_cas, core_strobe, core_cke, core_data_oe, port_func_en, area5_card_sel;
    logic area6_card_sel, card_io_wide_in_n, release_request_in_n, wait_in_n;
    logic width_pin_a_in, width_pin_b_in, endian_pin_in, core_wait, core_card_wide;
    logic core_released, endian_little, addr_oe, strobe_oe, cycle_start_out_n, rd_wr_out;
    logic row_strobe_n, col_strobe_lane0_n, col_strobe_lane1_n, col_strobe_lane2_n;
    logic col_strobe_lane3_n, lane0_enable, lane1_enable, lane2_enable, lane3_enable;
    logic read_strobe_n, cke_out, release_ack_out_n, width_pin_a_out, width_pin_a_oe;
    logic width_pin_b_out, width_pin_b_oe, endian_pin_out, endian_pin_oe;
    emb_pkg::emb_kind_t core_kind;
    logic [2:0]  core_area, memory_type_field;
    logic [3:0]  core_lanes;
    logic [7:0]  port_dir, port_out, port_in;
    logic [25:0] core_addr, addr_out;
    logic [31:0] core_wdata, data_in, core_rdata, data_out, data_oe;
    logic [6:0]  area_selects_n;
    logic [1:0]  area0_width;
    int error_cnt = 0, checked = 0;
    always #5 clock = ~clock;
    emb_pin_functions u_dut (.*);
    emb_mem_model u_mem (.clock(clock), .slow(slow), .data_out(data_out), .data_oe(data_oe),
                         .data_in(data_in), .wait_in_n(wait_in_n));
    task results();
        $display("errors %0d of %0d compares", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task step();
        @(posedge clock);
        @(negedge clock);
    endtask
    task t_read();
        core_active = 1; core_area = 3'h2; core_cycle_start = 1; core_strobe = 1; core_cke = 1;
        step();
        chk(area_selects_n, 7'h7B);
        chk(cycle_start_out_n, 1'h0);
        chk(read_strobe_n, 1'h0);
        chk(rd_wr_out, 1'h1);
        chk(cke_out, 1'h1);
        core_cycle_start = 0; core_burst_data = 1;
        step();
        chk(cycle_start_out_n, 1'h0);
        core_burst_data = 0;
        step();
        chk(cycle_start_out_n, 1'h1);
        core_active = 0; core_strobe = 0;
    endtask
    task t_card();
        area5_card_sel = 1; core_kind = emb_pkg::KIND_CARD; core_area = 3'h5;
        core_lanes = 4'h2; core_write = 1; core_strobe = 1; core_active = 1;
        step();
        chk(area_selects_n, 7'h5F);
        chk(width_pin_a_oe, 1'h1);
        chk(width_pin_a_out, 1'h0);
        chk(lane1_enable, 1'h0);
        chk(rd_wr_out, 1'h0);
        core_active = 0; core_strobe = 0; area5_card_sel = 0;
        step();
        chk(width_pin_a_oe, 1'h0);
    endtask
    task t_release();
        release_request_in_n = 0;
        step();
        chk({release_ack_out_n, addr_oe, strobe_oe, core_released}, 4'h1);
        release_request_in_n = 1;
        step();
        chk({release_ack_out_n, addr_oe, strobe_oe}, 3'h7);
    endtask
    task t_misc();
        memory_type_field = 3'h5; port_func_en = 1; port_dir = 8'hFF; port_out = 8'hA5; slow = 1;
        core_data_oe = 1;
        step();
        step();
        chk(endian_pin_oe, 1'h1);
        chk({data_oe[31:16], data_out[23:16]}, 24'h00FFA5);
        chk(port_in, 8'hA5);
        chk(core_wait, 1'h1);
        memory_type_field = 3'h4;
        step();
        chk(endian_pin_oe, 1'h0);
        chk({area0_width, endian_little}, 3'h3);
    endtask
    task t_kinds();
        port_func_en = 0; slow = 0; core_kind = emb_pkg::KIND_DRAM; core_area = 3'h3;
        core_active = 1; core_ras = 1; core_cas = 1; core_lanes = 4'hA; core_strobe = 1;
        core_write = 1; core_addr = 26'h2ABCDEF; core_wdata = 32'h12345678;
        step();
        chk({row_strobe_n, col_strobe_lane3_n, col_strobe_lane2_n, col_strobe_lane1_n,
             col_strobe_lane0_n}, 5'h05);
        chk({lane3_enable, lane2_enable, lane1_enable, lane0_enable}, 4'h5);
        chk(data_out, 32'h12345678);
        chk(data_oe, 32'hFFFFFFFF);
        chk(addr_out, 32'h02ABCDEF);
        memory_type_field = 3'h5; core_area = 3'h2; core_lanes = 4'h1;
        step();
        chk({row_strobe_n, col_strobe_lane3_n, col_strobe_lane2_n, col_strobe_lane1_n,
             col_strobe_lane0_n, endian_pin_out, endian_pin_oe}, 7'h6D);
        chk(core_rdata, 32'h12345678);
        core_kind = emb_pkg::KIND_SDRAM; core_lanes = 4'h6; core_write = 0;
        step();
        chk({lane3_enable, lane2_enable, lane1_enable, lane0_enable, col_strobe_lane0_n,
             row_strobe_n, read_strobe_n}, 7'h48);
        core_kind = emb_pkg::KIND_PSRAM;
        step();
        chk({row_strobe_n, col_strobe_lane0_n}, 2'h0);
        core_kind = emb_pkg::KIND_CARD; core_area = 3'h6; area6_card_sel = 1; core_card_io = 1;
        core_lanes = 4'h2; card_io_wide_in_n = 0;
        step();
        chk({lane3_enable, lane2_enable, lane1_enable,
             width_pin_b_out, width_pin_b_oe}, 5'h15);
        chk({area_selects_n, core_card_wide}, 8'h7F);
        core_write = 1;
        step();
        chk({lane3_enable, lane2_enable, lane1_enable}, 3'h2);
        core_active = 0; core_strobe = 0; core_card_io = 0; core_ras = 0; core_cas = 0;
        area6_card_sel = 0; core_data_oe = 0;
    endtask
    task t_reset();
        rst_n = 0; {width_pin_b_in, endian_pin_in} = 2'h2;
        step();
        step();
        rst_n = 1;
        step();
        chk({area0_width, endian_little, core_card_wide}, 4'h8);
    endtask
    initial begin
        {core_active, core_cycle_start, core_burst_data, core_write, core_card_io, core_ras,
         core_cas, core_strobe, core_cke, core_data_oe, port_func_en, area5_card_sel,
         area6_card_sel, core_area, memory_type_field, core_lanes, port_dir, port_out,
         core_addr, core_wdata, width_pin_b_in} = '0;
        {card_io_wide_in_n, release_request_in_n, width_pin_a_in, endian_pin_in} = 4'hF;
        core_kind = emb_pkg::KIND_NORMAL;
        repeat (6) @(negedge clock);
        rst_n = 1;
        {width_pin_a_in, endian_pin_in} = 2'h0;
        step();
        t_read();
        t_card();
        t_release();
        t_misc();
        t_kinds();
        t_reset();
        results();
    end
    initial begin
        #20000;
        error_cnt++;
        results();
    end
endmodule
